/* File: logic/ops_prog_seq.sv */
// Purpose: Programmer that runs the rapid programming algorithm on an OTP memory.
// Assumes: Source bytes come from the user port on request; inputs are synchronous.
// Notes:   Rails are requested as levels; outside regulators settle within setup time.
// Function
// - Each program pulse is held low nominally 100 us, within 95 to 105 us.
// - Programming starts at the first address, then raises main to 6.5V and prog to 13.0V.
// - The first pass gives every address exactly one pulse with no verify.
// - The second pass verifies each address, with at most 10 more pulses each verified.
// - A byte still failing after 10 retries stops the job and flags the part failed.
// - A verified byte advances the address until every location is checked.
// - After verify both rails drop to 5.0V and every byte is read back and compared.
// - The main rail switches on no later and off no earlier than the prog rail.
// - Ident mode holds the ident select line at the high ident voltage during reads.
`timescale 1ns/1ps
module ops_prog_seq
  import ops_pkg::*;
#(
  parameter int unsigned PW_CYC    = OPS_PW_CYC,
  parameter int unsigned SETUP_CYC = OPS_SETUP_CYC,
  parameter int unsigned LAST_ADDR = (1 << OPS_ADDR_W) - 1
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  start_prog,
  input  wire logic                  start_ident,
  input  wire logic [OPS_DATA_W-1:0] src_data,
  input  wire logic [OPS_DATA_W-1:0] data_in,
  output logic      [OPS_ADDR_W-1:0] src_addr,
  output ops_pins_t                  pins,
  output ops_result_t                result
);

  typedef enum {
    S_IDLE, S_MAIN_UP, S_PROG_UP, S_SETUP, S_PULSE, S_HOLD, S_VREAD, S_VCMP,
    S_PROG_DN, S_MAIN_DN, S_RSETUP, S_RREAD, S_SHUT, S_ISETUP, S_IREAD, S_END
  } ops_state_t;

  localparam int unsigned TW = 16;

  ops_state_t                state;
  logic                      pass_two;
  logic                      fail_seen;
  logic [OPS_RETRY_W-1:0]    retry;
  logic                      t_load;
  logic [TW-1:0]             t_val;
  logic [TW-1:0]             low_run;
  logic                      t_done;
  logic                      at_last;

  assign at_last = (pins.addr == OPS_ADDR_W'(LAST_ADDR));
  assign src_addr = pins.addr;

  ops_pulse_timer #(.CNT_W(TW)) u_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (t_load),
    .load_val (t_val),
    .busy     (),
    .done     (t_done)
  );

  // Timer loads on entry to each timed state
  always_comb begin
    t_load = 1'b0;
    t_val  = TW'(SETUP_CYC);
    case (state)
      S_IDLE:    t_load = start_prog || start_ident;
      S_MAIN_UP, S_PROG_UP, S_HOLD, S_PROG_DN, S_MAIN_DN:
        t_load = t_done;
      S_SETUP: begin
        t_load = t_done;
        // Done is seen a cycle after it fires, so load one less
        t_val  = TW'(PW_CYC - 1);
      end
      S_PULSE:   t_load = t_done;
      S_VCMP:    t_load = 1'b1;
      S_RREAD, S_ISETUP: t_load = t_done;
      default:   t_load = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state     <= S_IDLE;
      pass_two  <= 1'b0;
      fail_seen <= 1'b0;
      retry     <= '0;
      pins      <= '{addr: '0, data_out: '0, data_oe_n: 1'b1, chip_enable_n: 1'b1,
                     output_enable_n: 1'b1, program_strobe_n: 1'b1,
                     main_supply_on: 1'b0, prog_supply_on: 1'b0,
                     main_supply_high: 1'b0, prog_supply_high: 1'b0,
                     ident_select_high: 1'b0};
      result    <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start_prog) begin
            pins.addr          <= '0;
            pins.main_supply_on   <= 1'b1;
            pins.main_supply_high <= 1'b1;
            pass_two  <= 1'b0;
            fail_seen <= 1'b0;
            result    <= '0;
            state     <= S_MAIN_UP;
          end else if (start_ident) begin
            pins.addr              <= '0;
            pins.main_supply_on    <= 1'b1;
            pins.chip_enable_n     <= 1'b0;
            pins.output_enable_n   <= 1'b0;
            pins.ident_select_high <= 1'b1;
            result    <= '0;
            state     <= S_ISETUP;
          end
        end
        S_MAIN_UP: if (t_done) begin
          pins.prog_supply_on   <= 1'b1;
          pins.prog_supply_high <= 1'b1;
          state <= S_PROG_UP;
        end
        S_PROG_UP: if (t_done) begin
          pins.chip_enable_n <= 1'b0;
          pins.data_out      <= src_data;
          pins.data_oe_n     <= 1'b0;
          state <= S_SETUP;
        end
        S_SETUP: if (t_done) begin
          pins.program_strobe_n <= 1'b0;
          state <= S_PULSE;
        end
        S_PULSE: if (t_done) begin
          pins.program_strobe_n <= 1'b1;
          state <= S_HOLD;
        end
        S_HOLD: if (t_done) begin
          pins.data_oe_n <= 1'b1;
          if (pass_two) begin
            pins.output_enable_n <= 1'b0;
            state <= S_VREAD;
          end else if (at_last) begin
            pass_two  <= 1'b1;
            retry     <= '0;
            pins.addr <= '0;
            pins.output_enable_n <= 1'b0;
            state <= S_VREAD;
          end else begin
            pins.addr <= pins.addr + OPS_ADDR_W'(1);
            state <= S_PROG_UP;
          end
        end
        S_VREAD: if (t_done) state <= S_VCMP;
        S_VCMP: begin
          pins.output_enable_n <= 1'b1;
          if (data_in == src_data) begin
            retry <= '0;
            if (at_last) begin
              pins.prog_supply_high <= 1'b0;
              state <= S_PROG_DN;
            end else begin
              pins.addr <= pins.addr + OPS_ADDR_W'(1);
              pins.output_enable_n <= 1'b0;
              state <= S_VREAD;
            end
          end else if (retry == OPS_RETRY_W'(OPS_MAX_RETRY)) begin
            result.verify_fail <= 1'b1;
            result.fail_addr   <= pins.addr;
            pins.prog_supply_high <= 1'b0;
            pins.prog_supply_on   <= 1'b0;
            state <= S_SHUT;
          end else begin
            retry <= retry + OPS_RETRY_W'(1);
            pins.data_out  <= src_data;
            pins.data_oe_n <= 1'b0;
            state <= S_SETUP;
          end
        end
        S_PROG_DN: if (t_done) begin
          pins.main_supply_high <= 1'b0;
          state <= S_MAIN_DN;
        end
        S_MAIN_DN: if (t_done) begin
          pins.addr <= '0;
          pins.output_enable_n <= 1'b0;
          state <= S_RSETUP;
        end
        S_RSETUP: state <= S_RREAD;
        S_RREAD: if (t_done) begin
          if (data_in != src_data && !fail_seen) begin
            fail_seen <= 1'b1;
            result.readback_fail <= 1'b1;
            result.fail_addr     <= pins.addr;
          end
          if (at_last) begin
            pins.output_enable_n <= 1'b1;
            pins.prog_supply_on  <= 1'b0;
            state <= S_SHUT;
          end else begin
            pins.addr <= pins.addr + OPS_ADDR_W'(1);
            state <= S_RSETUP;
          end
        end
        S_ISETUP: if (t_done) begin
          if (pins.addr[0]) begin
            result.type_code  <= data_in;
            pins.ident_select_high <= 1'b0;
            pins.output_enable_n   <= 1'b1;
            state <= S_SHUT;
          end else begin
            result.maker_code <= data_in;
            pins.addr[0] <= 1'b1;
            state <= S_IREAD;
          end
        end
        S_IREAD: state <= S_ISETUP;
        S_SHUT: begin
          // Main rail drops a cycle after the prog rail at the earliest
          pins.main_supply_on   <= pins.prog_supply_on;
          pins.main_supply_high <= 1'b0;
          pins.chip_enable_n    <= 1'b1;
          pins.output_enable_n  <= 1'b1;
          pins.data_oe_n        <= 1'b1;
          pins.prog_supply_on   <= 1'b0;
          state <= S_END;
        end
        S_END: begin
          pins.main_supply_on <= 1'b0;
          result.done <= 1'b1;
          result.pass <= !result.verify_fail && !result.readback_fail;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Strobe-low run length; a counter keeps the width check free of long delays
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) low_run <= '0;
    else low_run <= pins.program_strobe_n ? '0 : low_run + TW'(1);
  end

  property p_pulse_width;
    @(posedge core_clk) disable iff (!nrst)
      $rose(pins.program_strobe_n) |-> low_run == TW'(PW_CYC);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("strobe width off");

  property p_main_first;
    @(posedge core_clk) disable iff (!nrst)
      pins.prog_supply_on |-> pins.main_supply_on;
  endproperty
  a_main_first: assert property (p_main_first) else $error("rail order broken");

  property p_verify_quiet;
    @(posedge core_clk) disable iff (!nrst)
      !pins.output_enable_n |-> pins.program_strobe_n && pins.data_oe_n;
  endproperty
  a_verify_quiet: assert property (p_verify_quiet) else $error("read while strobing");

  property p_retry_cap;
    @(posedge core_clk) disable iff (!nrst)
      retry <= OPS_RETRY_W'(OPS_MAX_RETRY);
  endproperty
  a_retry_cap: assert property (p_retry_cap) else $error("too many retries");

  property p_fail_stops;
    @(posedge core_clk) disable iff (!nrst)
      $rose(result.verify_fail) |-> ##1 !pins.prog_supply_on ##1 result.done;
  endproperty
  a_fail_stops: assert property (p_fail_stops) else $error("failure did not stop");

  property p_first_pass_blind;
    @(posedge core_clk) disable iff (!nrst)
      !pass_two |-> pins.output_enable_n || pins.ident_select_high;
  endproperty
  a_first_pass_blind: assert property (p_first_pass_blind) else $error("verify in pass one");

  property p_readback_low;
    @(posedge core_clk) disable iff (!nrst)
      (state == S_RREAD) |-> !pins.prog_supply_high && !pins.main_supply_high;
  endproperty
  a_readback_low: assert property (p_readback_low) else $error("readback at high rails");

  property p_start_addr;
    @(posedge core_clk) disable iff (!nrst)
      (state == S_IDLE && start_prog) |=> pins.addr == '0 && pins.main_supply_high;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("bad start");

  c_retry:  cover property (@(posedge core_clk) retry == OPS_RETRY_W'(1));
  c_fail:   cover property (@(posedge core_clk) $rose(result.verify_fail));
  c_pass:   cover property (@(posedge core_clk) result.done && result.pass);
  c_ident:  cover property (@(posedge core_clk) state == S_IREAD);

endmodule

/* File: inc/ops_pkg.sv */
// Purpose: Shared constants and types for the OTP programming sequencer.
// Assumes: 200 MHz core clock; supply rails are switched by outside regulators.
// Notes:   Times are kept in their printed units; cycle counts derive from them.
package ops_pkg;

  localparam int unsigned OPS_CLK_MHZ     = 200;
  localparam int unsigned OPS_ADDR_W      = 18;
  localparam int unsigned OPS_DATA_W      = 8;
  // Pulse width limits and nominal, in microseconds
  localparam int unsigned OPS_PW_MIN_US   = 95;
  localparam int unsigned OPS_PW_NOM_US   = 100;
  localparam int unsigned OPS_PW_MAX_US   = 105;
  // Setup and hold times, in microseconds
  localparam int unsigned OPS_SETUP_US    = 2;
  localparam int unsigned OPS_PW_CYC      = OPS_PW_NOM_US * OPS_CLK_MHZ;
  localparam int unsigned OPS_PW_MIN_CYC  = OPS_PW_MIN_US * OPS_CLK_MHZ;
  localparam int unsigned OPS_PW_MAX_CYC  = OPS_PW_MAX_US * OPS_CLK_MHZ;
  localparam int unsigned OPS_SETUP_CYC   = OPS_SETUP_US * OPS_CLK_MHZ;
  localparam int unsigned OPS_MAX_RETRY   = 10;
  localparam int unsigned OPS_RETRY_W     = 4;

  // Rail select codes
  typedef enum logic [1:0] {
    OPS_RAIL_OFF  = 2'h0,
    OPS_RAIL_READ = 2'h1,
    OPS_RAIL_PROG = 2'h2,
    OPS_RAIL_IDENT = 2'h3
  } ops_rail_t;

  // Pins toward the memory
  typedef struct packed {
    logic [OPS_ADDR_W-1:0] addr;
    logic [OPS_DATA_W-1:0] data_out;
    logic                  data_oe_n;
    logic                  chip_enable_n;
    logic                  output_enable_n;
    logic                  program_strobe_n;
    logic                  main_supply_on;
    logic                  prog_supply_on;
    logic                  main_supply_high;
    logic                  prog_supply_high;
    logic                  ident_select_high;
  } ops_pins_t;

  // Outcome of a job
  typedef struct packed {
    logic                  done;
    logic                  pass;
    logic                  verify_fail;
    logic                  readback_fail;
    logic [OPS_ADDR_W-1:0] fail_addr;
    logic [OPS_DATA_W-1:0] maker_code;
    logic [OPS_DATA_W-1:0] type_code;
  } ops_result_t;

endpackage

/* File: logic/ops_pulse_timer.sv */
// Purpose: Down counter that times strobes and setup waits.
// Assumes: Load and count on the core clock.
// Notes:   done is a one-cycle pulse as the count reaches zero.
`timescale 1ns/1ps
module ops_pulse_timer
  import ops_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  busy,
  output logic                  done
);

  logic [CNT_W-1:0] count;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (load) begin
      count <= load_val;
      busy  <= 1'b1;
      done  <= 1'b0;
    end else if (busy) begin
      done  <= (count == CNT_W'(1));
      busy  <= (count != CNT_W'(1));
      count <= count - CNT_W'(1);
    end else begin
      done <= 1'b0;
    end
  end

endmodule

/* File: dv/ops_otp_model.sv */
// Purpose: Behavioural OTP memory that answers the sequencer's pins.
// Assumes: Four locations are enough; addr bits above 1 are ignored.
// Notes:   Cells take a byte from the need-th pulse on, to exercise retries.
`timescale 1ns/1ps
module ops_otp_model
  import ops_pkg::*;
#(
  parameter int unsigned PW_CYC     = 20,
  parameter logic [7:0]  MAKER_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0]  TYPE_CODE  = 8'hC3  // Arbitrary value
) (
  input  wire logic                  core_clk,
  input  wire ops_pins_t             pins,
  output logic      [OPS_DATA_W-1:0] data_outputs
);
  logic [7:0] mem [4];
  int         pulses [4];
  int         need [4];
  int         low_cnt;
  int         pw_err;
  int         rail_err;
  int         first_addr;
  logic [1:0] a;

  assign a = pins.addr[1:0];

  // Erased state is all ones; a blank part per job
  task automatic wipe();
    for (int i = 0; i < 4; i++) begin
      mem[i] = 8'hFF;
      pulses[i] = 0;
      need[i] = 1;
    end
    low_cnt = 0;
    pw_err = 0;
    rail_err = 0;
    first_addr = -1;
  endtask

  initial begin
    wipe();
    data_outputs = 8'hA5;
  end

  always @(posedge core_clk) begin
    if (pins.prog_supply_on && !pins.main_supply_on) rail_err++;
    if (!pins.program_strobe_n) begin
      low_cnt++;
      if (low_cnt == 1) begin
        pulses[a]++;
        if (first_addr < 0) first_addr = int'(a);
        if (!(pins.main_supply_high && pins.prog_supply_high)) rail_err++;
        if (pulses[a] >= need[a] && !pins.chip_enable_n) mem[a] = mem[a] & pins.data_out;
      end
    end else if (low_cnt != 0) begin
      if (low_cnt != PW_CYC) pw_err++;
      low_cnt = 0;
    end
    // Outputs float otherwise; toggling keeps a stale byte from passing
    if (!pins.chip_enable_n && !pins.output_enable_n && pins.program_strobe_n) begin
      if (pins.ident_select_high) data_outputs <= a[0] ? TYPE_CODE : MAKER_CODE;
      else data_outputs <= mem[a];
    end else begin
      data_outputs <= ~data_outputs;
    end
  end
endmodule

/* File: dv/otp_rom_program_sequencer_test.sv */
// Purpose: Self-checking bench for the OTP programming sequencer.
// Assumes: Shortened pulse, setup and address counts for simulation.
// Notes:   Expected outcome is worked out from the per-cell pulse needs.
`timescale 1ns/1ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin fail_count++; \
  $display("[FAIL] %0t got %0h want %0h", $time, act, exp); end end
module otp_rom_program_sequencer_test;
  import ops_pkg::*;
  localparam int unsigned PW   = 20;
  localparam int unsigned SU   = 4;
  localparam int unsigned LAST = 3;

  logic                  core_clk;
  logic                  nrst;
  logic                  start_prog;
  logic                  start_ident;
  logic [OPS_DATA_W-1:0] src_data;
  logic [OPS_DATA_W-1:0] data_in;
  logic [OPS_ADDR_W-1:0] src_addr;
  ops_pins_t             pins;
  ops_result_t           result;
  logic [7:0]            src_mem [4];
  logic [31:0]           seed;
  int                    fail_count;
  int                    comparisons;

  assign src_data = src_mem[src_addr[1:0]];

  ops_prog_seq #(.PW_CYC(PW), .SETUP_CYC(SU), .LAST_ADDR(LAST)) dut_u (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .start_prog  (start_prog),
    .start_ident (start_ident),
    .src_data    (src_data),
    .data_in     (data_in),
    .src_addr    (src_addr),
    .pins        (pins),
    .result      (result)
  );

  ops_otp_model #(.PW_CYC(PW)) mem_u (
    .core_clk     (core_clk),
    .pins         (pins),
    .data_outputs (data_in)
  );

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic close_out();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic run_job(input bit prog);
    bit got;
    got = 0;
    @(posedge core_clk);
    if (prog) start_prog <= 1'b1;
    else start_ident <= 1'b1;
    @(posedge core_clk);
    start_prog <= 1'b0;
    start_ident <= 1'b0;
    for (int i = 0; i < 50000 && !got; i++) begin
      @(posedge core_clk);
      #1;
      if (result.done === 1'b1) got = 1;
    end
    if (!got) begin
      fail_count++;
      $display("[FAIL] %0t job never finished", $time);
      close_out();
    end
  endtask

  // Program a fresh part whose cells need the given pulse counts
  task automatic prog_case(input int n0, input int n1, input int n2, input int n3);
    int nd [4];
    int bad;
    int exp_p;
    nd = '{n0, n1, n2, n3};
    bad = -1;
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      // An erased cell must never match its source byte by chance
      src_mem[i] <= seed[7:0] & 8'hFE;
      if (bad < 0 && nd[i] > OPS_MAX_RETRY + 1) bad = i;
    end
    mem_u.wipe();
    for (int i = 0; i < 4; i++) mem_u.need[i] = nd[i];
    run_job(1'b1);
    `CHK(result.pass, logic'(bad < 0))
    `CHK(result.verify_fail, logic'(bad >= 0))
    if (bad >= 0) `CHK(result.fail_addr, OPS_ADDR_W'(bad))
    else `CHK(result.readback_fail, 1'b0)
    for (int i = 0; i < 4; i++) begin
      exp_p = (bad >= 0 && i > bad) ? 1 : (nd[i] > OPS_MAX_RETRY + 1 ? OPS_MAX_RETRY + 1 : nd[i]);
      `CHK(mem_u.pulses[i], exp_p)
      if (bad < 0) `CHK(mem_u.mem[i], src_mem[i])
    end
    `CHK(mem_u.first_addr, 0)
    `CHK(mem_u.rail_err, 0)
    `CHK(mem_u.pw_err, 0)
    `CHK(pins.prog_supply_on, 1'b0)
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    nrst = 1'b0;
    start_prog = 1'b0;
    start_ident = 1'b0;
    seed = 32'd92;
    fail_count = 0;
    comparisons = 0;
    for (int i = 0; i < 4; i++) src_mem[i] = 8'hFF;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    // Identification codes, selected by the lowest address line
    run_job(1'b0);
    `CHK(result.maker_code, mem_u.MAKER_CODE)
    `CHK(result.type_code, mem_u.TYPE_CODE)
    // Every cell takes its byte on the blind pass
    prog_case(1, 1, 1, 1);
    // Slow cells, one needing exactly the full ten retries
    prog_case(1, 11, 4, 1);
    // A cell that never takes stops the job after ten retries
    prog_case(1, 12, 1, 1);
    prog_case(99, 1, 1, 1);
    close_out();
  end
endmodule
